// ===== nacd_addr_pack.sv
// Builds the flat array address from the field request
module nacd_addr_pack
  import nacd_pkg::*;
(
  input  wire nacd_req_t            req_i,
  output logic [NACD_ADDR_W-1:0]    addr_o,
  output logic [2:0]                ncyc_o
);

  logic [NACD_BLK_W-1:0] blk_m;

  always_comb begin
    // Only the bits the density owns survive
    unique case (req_i.dens)
      NACD_D512M: blk_m = req_i.block & 11'h01FF;
      NACD_D1G:   blk_m = req_i.block & 11'h03FF;
      default:    blk_m = req_i.block;
    endcase
    addr_o = '0;
    if (req_i.x16) begin
      addr_o[NACD_COL_W_X16-1:0] = req_i.column[NACD_COL_W_X16-1:0];
      addr_o[16:11] = req_i.page;
      addr_o[27:17] = blk_m;
      if (req_i.dens == NACD_D4G) begin
        addr_o[NACD_DIE_BIT_X16] = req_i.die;
      end
    end else begin
      addr_o[NACD_COL_W_X8-1:0] = req_i.column;
      addr_o[17:12] = req_i.page;
      addr_o[28:18] = blk_m;
      if (req_i.dens == NACD_D4G) begin
        addr_o[NACD_DIE_BIT_X8] = req_i.die;
      end
    end
    // Two largest densities need the fifth cycle
    ncyc_o = (req_i.dens[1]) ? NACD_CYC5 : NACD_CYC4;
  end

endmodule // nacd_addr_pack

// ===== nacd_dev_model.sv
module nacd_dev_model
  import nacd_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire nacd_pins_t        pins_i,
  input  wire logic              oe_b_i,
  input  wire logic              cmd_i,
  input  wire logic              x16_i,
  input  wire nacd_density_t     dens_i,
  output logic [NACD_ADDR_W-1:0] addr_o,
  output logic [2:0]             ncyc_o,
  output logic                   die_o,
  output logic                   err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Address cycle capture
  // ----------------------------------------------------------------
  logic [7:0] cyc_q [5];
  logic [7:0] c5;
  logic       we_q;
  logic       latch;
  logic       bad;
  assign latch = pins_i.we && !we_q && pins_i.ale;
  assign c5 = dens_i[1] ? cyc_q[4] : 8'h00;
  always_comb begin
    bad = oe_b_i || pins_i.io[15:8] != 8'h00;
    if (ncyc_o == 3'h1)
      bad = bad || (x16_i ? pins_i.io[7:3] != 5'h00
                          : pins_i.io[7:4] != 4'h0);
    if (ncyc_o == 3'h4)
      bad = bad || pins_i.io[7:2] != 6'h00;
    if (x16_i)
      addr_o = {1'b0, c5[1:0], cyc_q[3], cyc_q[2], cyc_q[1][2:0], cyc_q[0]};
    else
      addr_o = {c5[1:0], cyc_q[3], cyc_q[2], cyc_q[1][3:0], cyc_q[0]};
  end
  always_ff @(posedge clk_i) begin
    we_q <= pins_i.we;
    err_o <= rst_b_i && (err_o || (latch && bad));
    if (!rst_b_i || cmd_i) begin
      ncyc_o <= 3'h0;
      cyc_q <= '{default: 8'h00};
    end else if (latch) begin
      if (ncyc_o < 3'h5)
        cyc_q[ncyc_o] <= pins_i.io[7:0];
      ncyc_o <= ncyc_o + 3'h1;
    end
  end
  // Die choice survives until the next 4 Gb address phase
  always_ff @(posedge clk_i) begin
    if (!rst_b_i)
      die_o <= 1'b0;
    else if (ncyc_o != 3'h0 && dens_i == NACD_D4G)
      die_o <= addr_o[x16_i ? 28 : 29];
  end
endmodule // nacd_dev_model

// ===== nacd_host.sv
// ------------------------------------------------------------------
// How it works
// - Address goes out as four or five back-to-back cycles, low bits first.
// - Byte-wide column is bits 0-11; cycle 2 upper nibble low.
// - Byte-wide fifth cycle: bit 28 on IO0, bit 29 on IO1.
// - Byte-wide 2/4 Gb: cycle 3 bits 12-19, cycle 4 bits 20-27.
// - Word-wide column bits 0-10; IO8-IO15 always low.
// - Word-wide fifth cycle: bit 27 on IO0, bit 28 on IO1.
// ------------------------------------------------------------------
module nacd_host
  import nacd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire nacd_req_t  req_i,
  input  wire logic       req_valid_i,
  input  wire logic       cmd_start_i,
  output logic            req_ready_o,
  output nacd_pins_t      pins_o,
  output logic            io_oe_b_o,
  output logic            die_sel_o,
  output logic            busy_o
);

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NACD_IDLE  = 2'b00,
    NACD_SETUP = 2'b01,
    NACD_STROBE = 2'b10
  } nacd_state_t;

  nacd_state_t            st_q, st_d;
  logic [2:0]             cyc_q, cyc_d;
  logic [2:0]             ncyc_q, ncyc_d;
  logic                   x16_q, x16_d;
  logic [NACD_ADDR_W-1:0] addr_q, addr_d;
  nacd_pins_t             pins_q, pins_d;
  logic                   die_q, die_d;
  logic [NACD_ADDR_W-1:0] addr_w;
  logic [2:0]             ncyc_w;

  nacd_addr_pack u_pack (
    .req_i  (req_i),
    .addr_o (addr_w),
    .ncyc_o (ncyc_w)
  );

  // Byte carried by a given cycle, upper IO lines forced low
  function automatic logic [NACD_IO_W-1:0] cyc_byte(
    input logic [NACD_ADDR_W-1:0] a,
    input logic                   x16,
    input logic [2:0]             c
  );
    logic [7:0] b;
    b = 8'h00;
    if (x16) begin
      unique case (c)
        3'h0: b = a[7:0];
        3'h1: b = {5'h00, a[10:8]};
        3'h2: b = a[18:11];
        3'h3: b = a[26:19];
        default: b = {6'h00, a[28:27]};
      endcase
    end else begin
      unique case (c)
        3'h0: b = a[7:0];
        3'h1: b = {4'h0, a[11:8]};
        3'h2: b = a[19:12];
        3'h3: b = a[27:20];
        default: b = {6'h00, a[29:28]};
      endcase
    end
    return {8'h00, b};
  endfunction

  always_comb begin
    st_d   = st_q;
    cyc_d  = cyc_q;
    ncyc_d = ncyc_q;
    x16_d  = x16_q;
    addr_d = addr_q;
    pins_d = pins_q;
    die_d  = die_q;
    unique case (st_q)
      NACD_IDLE: begin
        pins_d = '0;
        if (req_valid_i) begin
          // New address phase always starts at cycle one
          addr_d = addr_w;
          ncyc_d = ncyc_w;
          x16_d  = req_i.x16;
          cyc_d  = 3'h0;
          // Remember die for later addressless commands
          if (req_i.dens == NACD_D4G) begin
            die_d = req_i.die;
          end
          st_d = NACD_SETUP;
        end
      end
      NACD_SETUP: begin
        pins_d.ale = 1'b1;
        pins_d.we  = 1'b0;
        pins_d.io  = cyc_byte(addr_q, x16_q, cyc_q);
        st_d = NACD_STROBE;
      end
      NACD_STROBE: begin
        // Rising write strobe latches this cycle
        pins_d.we = 1'b1;
        if (cyc_q == ncyc_q - 3'h1) begin
          st_d = NACD_IDLE;
        end else begin
          cyc_d = cyc_q + 3'h1;
          st_d  = NACD_SETUP;
        end
      end
      default: st_d = NACD_IDLE;
    endcase
    if (cmd_start_i && st_q == NACD_IDLE && !req_valid_i) begin
      cyc_d = 3'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q   <= NACD_IDLE;
      cyc_q  <= 3'h0;
      ncyc_q <= NACD_CYC4;
      x16_q  <= 1'b0;
      addr_q <= '0;
      pins_q <= '0;
      die_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      cyc_q  <= cyc_d;
      ncyc_q <= ncyc_d;
      x16_q  <= x16_d;
      addr_q <= addr_d;
      pins_q <= pins_d;
      die_q  <= die_d;
    end
  end

  assign req_ready_o = (st_q == NACD_IDLE);
  assign busy_o      = (st_q != NACD_IDLE);
  assign pins_o      = pins_q;
  assign die_sel_o   = die_q;
  // Last cycle still stands one clock after idle, so keep driving it
  assign io_oe_b_o   = (st_q == NACD_IDLE) && !pins_q.ale;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_strobe;
    pins_o.ale && !pins_o.we ##1 pins_o.ale && pins_o.we;
  endsequence

  AST_UPPER_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pins_o.ale |-> pins_o.io[15:8] == 8'h00)
    else $error("upper io lines not low");
  AST_X8_C2: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == NACD_STROBE && !x16_q && cyc_q == 3'h1)
      |-> pins_o.io[7:4] == 4'h0)
    else $error("cycle 2 upper nibble not low");
  AST_C5_X8: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == NACD_STROBE && !x16_q && cyc_q == 3'h4)
      |-> pins_o.io[7:0] == {6'h00, addr_q[29:28]})
    else $error("byte-wide fifth cycle wrong");
  AST_C5_X16: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == NACD_STROBE && x16_q && cyc_q == 3'h4)
      |-> pins_o.io[7:0] == {6'h00, addr_q[28:27]})
    else $error("word-wide fifth cycle wrong");
  AST_C3_X8: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == NACD_STROBE && !x16_q && cyc_q == 3'h2)
      |-> pins_o.io[7:0] == addr_q[19:12])
    else $error("byte-wide third cycle wrong");
  AST_FIRST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == NACD_IDLE && req_valid_i) |=> cyc_q == 3'h0)
    else $error("phase did not start at cycle one");
  AST_BURST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == NACD_IDLE && req_valid_i) |-> ##2 s_strobe ##1 s_strobe
      ##1 s_strobe ##1 s_strobe)
    else $error("address cycles not back to back");
  AST_DIE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q == NACD_IDLE && req_valid_i && req_i.dens == NACD_D4G)
      |=> die_sel_o == $past(req_i.die))
    else $error("die select not updated");

endmodule // nacd_host

// ===== nacd_pkg.sv
package nacd_pkg;

  // ----------------------------------------------------------------
  // Densities and bus width
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NACD_D512M = 2'b00,
    NACD_D1G   = 2'b01,
    NACD_D2G   = 2'b10,
    NACD_D4G   = 2'b11
  } nacd_density_t;

  localparam int unsigned NACD_ADDR_W     = 30;
  localparam int unsigned NACD_IO_W       = 16;
  localparam int unsigned NACD_COL_W_X8   = 12;
  localparam int unsigned NACD_COL_W_X16  = 11;
  localparam int unsigned NACD_PAGE_W     = 6;
  localparam int unsigned NACD_BLK_W      = 11;
  localparam int unsigned NACD_BLK_W_2G   = 11;
  localparam int unsigned NACD_BLK_W_1G   = 10;
  localparam int unsigned NACD_BLK_W_512M = 9;
  localparam int unsigned NACD_DIE_BIT_X8  = 29;
  localparam int unsigned NACD_DIE_BIT_X16 = 28;
  localparam logic [2:0]  NACD_CYC4       = 3'h4;
  localparam logic [2:0]  NACD_CYC5       = 3'h5;

  // ----------------------------------------------------------------
  // Request carried from user into the cycle driver
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  x16;
    nacd_density_t         dens;
    logic                  die;
    logic [NACD_BLK_W-1:0] block;
    logic [NACD_PAGE_W-1:0] page;
    logic [NACD_COL_W_X8-1:0] column;
  } nacd_req_t;

  // Pin strobes for one address write cycle
  typedef struct packed {
    logic                 we;
    logic                 ale;
    logic [NACD_IO_W-1:0] io;
  } nacd_pins_t;

endpackage : nacd_pkg

// ===== tb_nand_address_cycle_decoder.sv
module tb_nand_address_cycle_decoder
  import nacd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk_i, rst_b_i, req_valid_i, cmd_start_i;
  logic                   req_ready_o, io_oe_b_o, die_sel_o, busy_o;
  logic                   m_die, m_err;
  nacd_req_t              req_i;
  nacd_pins_t             pins_o;
  logic [NACD_ADDR_W-1:0] m_addr;
  logic [2:0]             m_ncyc;
  int                     n_errors, check_count;
  nacd_host dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .cmd_start_i(cmd_start_i),
    .req_ready_o(req_ready_o), .pins_o(pins_o), .io_oe_b_o(io_oe_b_o),
    .die_sel_o(die_sel_o), .busy_o(busy_o));
  nacd_dev_model dev (.clk_i(clk_i), .rst_b_i(rst_b_i), .pins_i(pins_o),
    .oe_b_i(io_oe_b_o), .cmd_i(cmd_start_i), .x16_i(req_i.x16),
    .dens_i(req_i.dens), .addr_o(m_addr), .ncyc_o(m_ncyc), .die_o(m_die),
    .err_o(m_err));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [29:0] exp_addr(nacd_req_t r);
    int          cw, bw;
    logic [29:0] a;
    cw = r.x16 ? 11 : 12;
    bw = r.dens == NACD_D1G ? 10 : r.dens == NACD_D512M ? 9 : 11;
    a = 30'(r.column) & ((30'h1 << cw) - 30'h1);
    a |= 30'(r.page) << cw;
    a |= (30'(r.block) & ((30'h1 << bw) - 30'h1)) << (cw + 6);
    if (r.dens == NACD_D4G)
      a[r.x16 ? 28 : 29] = r.die;
    return a;
  endfunction
  // Junk keeps valid high with other data while busy
  task automatic send(nacd_req_t r, logic junk);
    int n;
    @(negedge clk_i);
    cmd_start_i = 1'b1;
    @(negedge clk_i);
    cmd_start_i = 1'b0;
    req_i = r;
    req_valid_i = 1'b1;
    @(negedge clk_i);
    req_i.block = ~r.block;
    req_valid_i = junk;
    repeat (3) @(negedge clk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 40) begin
      chk("ready", 1, 32'(req_ready_o));
      end_sim();
    end
    repeat (2) @(negedge clk_i);
  endtask
  task automatic check_req(nacd_req_t r, logic junk);
    send(r, junk);
    chk("addr", 32'(exp_addr(r)), 32'(m_addr));
    chk("ncyc", r.dens[1] ? 5 : 4, 32'(m_ncyc));
    chk("pins", 0, 32'(m_err));
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_layout();
    nacd_req_t r;
    for (int w = 0; w < 2; w++) begin
      for (int d = 0; d < 4; d++) begin
        r = '{x16: w[0], dens: nacd_density_t'(d), die: 1'b1,
              block: 11'h5a7, page: 6'h2d, column: w ? 12'h43e : 12'hc3e};
        check_req(r, 1'b0);
      end
    end
    $display("test layout done");
  endtask
  task automatic t_die();
    nacd_req_t r;
    for (int w = 0; w < 2; w++) begin
      r = '{x16: w[0], dens: NACD_D4G, die: 1'b0,
            block: 11'h7ff, page: 6'h3f, column: 12'h001};
      check_req(r, 1'b0);
      chk("die0", 0, 32'(die_sel_o));
      chk("mdie0", 0, 32'(m_die));
      r.die = 1'b1;
      check_req(r, 1'b0);
      chk("die1", 1, 32'(die_sel_o));
      chk("mdie1", 1, 32'(m_die));
      r.dens = NACD_D2G;
      r.die = 1'b0;
      check_req(r, 1'b0);
      chk("diekeep", 1, 32'(die_sel_o));
      chk("mdiekeep", 1, 32'(m_die));
    end
    $display("test die done");
  endtask
  task automatic t_refuse();
    nacd_req_t r;
    r = '{x16: 1'b0, dens: NACD_D1G, die: 1'b0,
          block: 11'h155, page: 6'h15, column: 12'h9a6};
    check_req(r, 1'b1);
    chk("idle", 0, 32'(busy_o));
    $display("test refuse done");
  endtask
  initial begin
    n_errors = 0;
    check_count = 0;
    rst_b_i = 1'b0;
    req_valid_i = 1'b0;
    cmd_start_i = 1'b0;
    req_i = '0;
    repeat (12) @(negedge clk_i);
    rst_b_i = 1'b1;
    chk("rst", 32'h0000_000C, {28'h0, req_ready_o, io_oe_b_o, busy_o,
        die_sel_o});
    chk("rstpins", 0, 32'(pins_o));
    t_layout();
    t_die();
    t_refuse();
    end_sim();
  end
endmodule // tb_nand_address_cycle_decoder
